// [core/hub_dma_regs.svh]
// register offsets, field positions and sizes of the hub dma controller
`ifndef HUB_DMA_REGS_SVH
`define HUB_DMA_REGS_SVH
// sizes
`define NUM_CH      24
`define NUM_DESC    128
`define NUM_SPOKE   8
`define NUM_LVL     8
// byte offsets on the register bus
`define OFF_CHCFG   12'h800
`define OFF_CTRL    12'hc00
`define OFF_SWTRIG  12'hc04
`define OFF_STALL   12'hc08
`define OFF_CANCEL  12'hc0c
`define OFF_STATUS  12'hc10
// field positions
`define CTRL_FAIR   0
`define SPOKE_MSB   18
`define SPOKE_LSB   16
`define LOC_MSB     15
`define LOC_LSB     11
`define LOC_SPOKE   3'h2
// descriptor word order
`define W_SRC       2'h0
`define W_DST       2'h1
`define W_CTL       2'h2
`define W_LNK       2'h3
// levels and counts
`define FAIR_LVL    3'h2
`define FULL_COUNT  17'h10000
`endif

// [core/hub_dma_pkg.sv]
// types shared by the hub dma controller
`include "hub_dma_regs.svh"
package hub_dma_pkg;
  typedef enum logic {ENG_IDLE, ENG_RUN} eng_e;
  typedef enum logic [1:0] {OWN_NONE, OWN_CPU, OWN_RD, OWN_WR} own_e;
  typedef enum logic [1:0] {CTX_NONE, CTX_NEXT, CTX_SAVED} ctx_e;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } spoke_out_s;
  typedef struct packed {
    logic [6:0] first;
    logic [4:0] chain_src;
    logic       chain_en;
    logic       rr_dis;
    logic [2:0] prio;
  } chcfg_s;
  typedef struct packed {
    logic [3:0]  rsv;
    logic        dst_inc;
    logic        src_inc;
    logic [1:0]  size;
    logic [6:0]  burst;
    logic        unb;
    logic [15:0] cnt;
  } desc_ctl_s;
  typedef struct packed {
    logic [20:0] rsv;
    logic        auto;
    logic        irq1;
    logic        irq0;
    logic        last;
    logic [6:0]  next;
  } desc_link_s;
  typedef struct packed {
    eng_e                       eng;
    logic [4:0]                 ch;
    logic [4:0]                 last;
    logic                       kill;
    logic                       fair_en;
    logic [5:0]                 slot;
    logic [`NUM_CH-1:0]         pend;
    logic [`NUM_CH-1:0]         stall;
    ctx_e [`NUM_CH-1:0]         ctxm;
    logic                       rd_busy;
    logic                       wr_busy;
    logic                       buf_full;
    logic [31:0]                src;
    logic [31:0]                dst;
    logic [31:0]                buf_d;
    logic [16:0]                rd_left;
    logic [16:0]                wr_left;
    logic [7:0]                 rb;
    logic [6:0]                 dsc;
    own_e [`NUM_SPOKE-1:0]      own;
    logic [`NUM_SPOKE-1:0]      owed;
    spoke_out_s [`NUM_SPOKE-1:0] sp;
    logic                       cpu_busy;
    logic                       cpu_ack;
    logic [31:0]                cpu_rdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [`NUM_CH-1:0]         irq0;
    logic [`NUM_CH-1:0]         irq1;
  } st_s;
endpackage : hub_dma_pkg

// [core/peripheral_hub_dma_controller.sv]
// central peripheral hub with router, arbiter and 24 channel dma engine
`timescale 1ns/1ps
`default_nettype none
`include "hub_dma_regs.svh"

module peripheral_hub_dma_controller
  import hub_dma_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // register bus
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // processor master
  input  wire logic                  cpu_req,
  input  wire logic                  cpu_we,
  input  wire logic [1:0]            cpu_size,
  input  wire logic [31:0]           cpu_addr,
  input  wire logic [31:0]           cpu_wdata,
  output logic                       cpu_ack,
  output logic [31:0]                cpu_rdata,
  // spokes
  output spoke_out_s [`NUM_SPOKE-1:0] spoke_o,
  input  wire logic [`NUM_SPOKE-1:0] spoke_ack,
  input  wire logic [`NUM_SPOKE-1:0][31:0] spoke_rdata,
  // triggers and completion
  input  wire logic [`NUM_CH-1:0]    trig_in,
  output logic [`NUM_CH-1:0]         done_irq0,
  output logic [`NUM_CH-1:0]         done_irq1
);

  // ********************************
  // storage
  // ********************************
  st_s         s;
  st_s         n;
  chcfg_s      cfg      [`NUM_CH];
  logic [31:0] dmem     [4*`NUM_DESC];
  logic [31:0] ctx_src  [`NUM_CH];
  logic [31:0] ctx_dst  [`NUM_CH];
  logic [16:0] ctx_left [`NUM_CH];
  logic [6:0]  ctx_dsc  [`NUM_CH];

  // combinational helpers
  desc_ctl_s          ctl;
  desc_link_s         lnk;
  desc_ctl_s          lctl;
  logic [6:0]         ld;
  logic [2:0]         bytes;
  logic [7:0]         bb;
  logic [5:0]         pk;
  logic [4:0]         c;
  logic               is_desc;
  logic               is_cfg;
  logic               hit;
  logic [31:0]        rdv;
  logic               apb_w;
  logic               apb_dw;
  logic               rd_want;
  logic               wr_want;
  logic               rd_go;
  logic               wr_go;
  logic               cw;
  logic               ww;
  logic               rw;
  logic               done;
  logic [`NUM_CH-1:0] swt;
  logic [`NUM_CH-1:0] cnl;
  logic [`NUM_CH-1:0] chain;
  logic [`NUM_CH-1:0] clr;
  logic               dm_we;
  logic [8:0]         dm_wa;
  logic [31:0]        dm_wd;
  logic               cfg_we;
  logic               ctx_we;
  logic [6:0]         ctx_dw;

  // ********************************
  // functions
  // ********************************
  // spoke number of an address
  function automatic logic [2:0] spk(input logic [31:0] a);
    spk = a[`SPOKE_MSB:`SPOKE_LSB];
  endfunction : spk

  // address falls in the hub-local descriptor pool
  function automatic logic loc(input logic [31:0] a);
    loc = (spk(a) == `LOC_SPOKE) && (a[`LOC_MSB:`LOC_LSB] == '0);
  endfunction : loc

  // byte count minus beat, floored at zero
  function automatic logic [16:0] sub_sat(input logic [16:0] a,
                                          input logic [2:0]  b);
    sub_sat = (a <= 17'(b)) ? '0 : a - 17'(b);
  endfunction : sub_sat

  // favoured fairness level from slot counter
  function automatic logic [2:0] fav(input logic [5:0] sl);
    fav = 3'h7;
    for (int i = 4; i >= 0; i--) begin
      if (sl[i]) fav = 3'(i) + `FAIR_LVL;
    end
  endfunction : fav

  // channel arbiter: {valid, channel}
  function automatic logic [5:0] pick(input logic [`NUM_CH-1:0] el);
    logic [`NUM_LVL-1:0] has;
    logic [2:0]          lv;
    logic                got;
    int                  idx;
    has = '0;
    lv  = '0;
    got = 1'b0;
    pick = '0;
    for (int i = 0; i < `NUM_CH; i++) begin
      if (el[i]) has[cfg[i].prio] = 1'b1;
    end
    for (int l = `NUM_LVL - 1; l >= 0; l--) begin
      if (has[l]) lv = 3'(l);
    end
    // fairness slot may lift a lower level
    if (s.fair_en && lv >= `FAIR_LVL && has[fav(s.slot)]) begin
      lv = fav(s.slot);
    end
    // opt-out channels head the line
    for (int i = `NUM_CH - 1; i >= 0; i--) begin
      if (el[i] && cfg[i].prio == lv && cfg[i].rr_dis) begin
        pick = {1'b1, 5'(i)};
        got  = 1'b1;
      end
    end
    // otherwise rotate after last grant
    for (int i = `NUM_CH; i >= 1; i--) begin
      idx = int'(s.last) + i;
      if (idx >= `NUM_CH) idx = idx - `NUM_CH;
      if (!got && el[idx] && cfg[idx].prio == lv) begin
        pick = {1'b1, 5'(idx)};
      end
    end
  endfunction : pick

  // ********************************
  // next state
  // ********************************
  // current descriptor fields
  assign ctl   = desc_ctl_s'(dmem[{s.dsc, `W_CTL}]);
  assign lnk   = desc_link_s'(dmem[{s.dsc, `W_LNK}]);
  assign bytes = 3'(ctl.size) + 3'h1;
  assign bb    = (ctl.burst == '0) ? 8'(bytes) : 8'(ctl.burst);

  always_comb begin
    n         = s;
    n.irq0    = '0;
    n.irq1    = '0;
    n.cpu_ack = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    pk = '0;  c = '0;  ld = '0;  lctl = '0;
    rd_want = 1'b0;  wr_want = 1'b0;
    rd_go = 1'b0;  wr_go = 1'b0;  done = 1'b0;
    cw = 1'b0;  ww = 1'b0;  rw = 1'b0;
    swt = '0;  cnl = '0;  chain = '0;  clr = '0;
    dm_we = 1'b0;  dm_wa = '0;  dm_wd = '0;
    cfg_we = 1'b0;  ctx_we = 1'b0;  ctx_dw = s.dsc;

    // register bus decode
    is_desc = ~paddr[11];
    is_cfg  = (paddr[11:7] == 5'(`OFF_CHCFG >> 7)) &&
              (paddr[6:2] < 5'(`NUM_CH));
    hit = is_desc || is_cfg ||
          (paddr inside {`OFF_CTRL, `OFF_SWTRIG, `OFF_STALL,
                         `OFF_CANCEL, `OFF_STATUS});
    if (is_desc) rdv = dmem[paddr[10:2]];
    else if (is_cfg) rdv = 32'(cfg[paddr[6:2]]);
    else begin
      case (paddr)
        `OFF_CTRL:   rdv = 32'(s.fair_en);
        `OFF_SWTRIG: rdv = 32'(s.pend);
        `OFF_STALL:  rdv = 32'(s.stall);
        `OFF_STATUS: rdv = 32'({s.eng == ENG_RUN, s.ch});
        default:     rdv = '0;
      endcase
    end
    // setup phase answers in the following access cycle
    if (psel && !penable) begin
      n.pready  = 1'b1;
      n.pslverr = ~hit;
      n.prdata  = hit ? rdv : '0;
    end
    apb_w  = psel && penable && s.pready && pwrite && hit;
    apb_dw = apb_w && is_desc;
    if (apb_dw) begin
      dm_we = 1'b1;
      dm_wa = paddr[10:2];
      dm_wd = pwdata;
    end
    cfg_we = apb_w && is_cfg;
    if (apb_w) begin
      case (paddr)
        `OFF_CTRL:   n.fair_en = pwdata[`CTRL_FAIR];
        `OFF_SWTRIG: swt = pwdata[`NUM_CH-1:0];
        `OFF_STALL:  n.stall = pwdata[`NUM_CH-1:0];
        `OFF_CANCEL: cnl = pwdata[`NUM_CH-1:0];
        default: ;
      endcase
    end

    // channel engine
    unique case (s.eng)
      ENG_IDLE: begin
        pk = pick(s.pend & ~s.stall);
        c  = pk[4:0];
        if (pk[5]) begin
          n.eng  = ENG_RUN;
          n.ch   = c;
          n.last = c;
          n.rb   = '0;
          n.kill = 1'b0;
          if (cfg[c].prio >= `FAIR_LVL) n.slot = s.slot + 6'h1;
          if (s.ctxm[c] == CTX_SAVED) begin
            // resume a preempted or stalled transfer
            n.dsc     = ctx_dsc[c];
            n.src     = ctx_src[c];
            n.dst     = ctx_dst[c];
            n.rd_left = ctx_left[c];
            n.wr_left = ctx_left[c];
          end else begin
            // fresh entry refetches the descriptor
            ld = (s.ctxm[c] == CTX_NEXT) ? ctx_dsc[c]
                                         : cfg[c].first;
            lctl      = desc_ctl_s'(dmem[{ld, `W_CTL}]);
            n.dsc     = ld;
            n.src     = dmem[{ld, `W_SRC}];
            n.dst     = dmem[{ld, `W_DST}];
            n.rd_left = (lctl.cnt == '0) ? `FULL_COUNT
                                         : 17'(lctl.cnt);
            n.wr_left = n.rd_left;
          end
        end
      end
      ENG_RUN: begin
        rd_want = !s.rd_busy && !s.buf_full && s.rb < bb &&
                  (ctl.unb || s.rd_left != '0) &&
                  !s.kill && !s.stall[s.ch];
        wr_want = s.buf_full && !s.wr_busy;
        // burst boundary: nothing in flight and no more reads
        if (!s.rd_busy && !s.wr_busy && !s.buf_full && !rd_want) begin
          n.eng  = ENG_IDLE;
          ctx_we = !s.kill;
          done   = !ctl.unb && s.wr_left == '0 && !s.kill;
          if (done) begin
            n.irq0[s.ch] = lnk.irq0;
            n.irq1[s.ch] = lnk.irq1;
            ctx_dw       = lnk.next;
            n.ctxm[s.ch] = lnk.last ? CTX_NONE : CTX_NEXT;
            clr[s.ch]    = lnk.last || !lnk.auto;
            for (int i = 0; i < `NUM_CH; i++) begin
              chain[i] = cfg[i].chain_en &&
                         cfg[i].chain_src == s.ch;
            end
          end else if (!s.kill) begin
            n.ctxm[s.ch] = CTX_SAVED;
          end
        end
        // hub-local pool is served without a spoke
        if (rd_want && loc(s.src)) begin
          rd_go      = 1'b1;
          n.buf_d    = dmem[s.src[10:2]];
          n.buf_full = 1'b1;
        end
        if (wr_want && loc(s.dst) && !apb_dw) begin
          wr_go     = 1'b1;
          dm_we     = 1'b1;
          dm_wa     = s.dst[10:2];
          dm_wd     = s.buf_d;
          n.wr_left = sub_sat(s.wr_left, bytes);
        end
      end
    endcase

    // spoke router and per-spoke arbitration
    for (int k = 0; k < `NUM_SPOKE; k++) begin
      if (s.sp[k].req) begin
        if (spoke_ack[k]) begin
          n.sp[k].req = 1'b0;
          n.own[k]    = OWN_NONE;
          unique case (s.own[k])
            OWN_CPU: begin
              n.cpu_ack   = 1'b1;
              n.cpu_rdata = spoke_rdata[k];
              n.cpu_busy  = 1'b0;
            end
            OWN_RD: begin
              n.buf_d    = spoke_rdata[k];
              n.buf_full = 1'b1;
              n.rd_busy  = 1'b0;
            end
            OWN_WR: begin
              n.wr_busy = 1'b0;
              n.wr_left = sub_sat(s.wr_left, bytes);
            end
            OWN_NONE: ;
          endcase
        end
      end else begin
        cw = cpu_req && !s.cpu_busy && !s.cpu_ack &&
             spk(cpu_addr) == 3'(k);
        ww = wr_want && !loc(s.dst) && spk(s.dst) == 3'(k);
        rw = rd_want && !loc(s.src) && spk(s.src) == 3'(k) && !ww;
        if (cw && (!(ww || rw) || !s.owed[k])) begin
          n.owed[k]  = ww || rw;
          n.cpu_busy = 1'b1;
          n.own[k]   = OWN_CPU;
          n.sp[k]    = '{1'b1, cpu_we, cpu_size, cpu_addr, cpu_wdata};
        end else if (ww) begin
          n.owed[k] = 1'b0;
          n.wr_busy = 1'b1;
          wr_go     = 1'b1;
          n.own[k]  = OWN_WR;
          n.sp[k]   = '{1'b1, 1'b1, ctl.size, s.dst, s.buf_d};
        end else if (rw) begin
          n.owed[k] = 1'b0;
          n.rd_busy = 1'b1;
          rd_go     = 1'b1;
          n.own[k]  = OWN_RD;
          n.sp[k]   = '{1'b1, 1'b0, ctl.size, s.src, 32'h0};
        end
      end
    end

    // address and count advance
    if (rd_go) begin
      n.src = s.src + (ctl.src_inc ? 32'(bytes) : 32'h0);
      n.rb  = s.rb + 8'(bytes);
      if (!ctl.unb) n.rd_left = sub_sat(s.rd_left, bytes);
    end
    if (wr_go) begin
      n.dst      = s.dst + (ctl.dst_inc ? 32'(bytes) : 32'h0);
      n.buf_full = 1'b0;
    end

    // pending requests: a new trigger beats any clear
    n.pend = (s.pend & ~(clr | cnl)) | trig_in | swt | chain;
    for (int i = 0; i < `NUM_CH; i++) begin
      if (cnl[i]) n.ctxm[i] = CTX_NONE;
    end
    if (n.eng == ENG_RUN && cnl[n.ch]) n.kill = 1'b1;
  end

  // ********************************
  // registers
  // ********************************
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= n;
  end

  // channel configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NUM_CH; i++) cfg[i] <= '0;
    end else if (cfg_we) begin
      cfg[paddr[6:2]] <= chcfg_s'(pwdata[$bits(chcfg_s)-1:0]);
    end
  end

  // descriptor pool and channel contexts
  always_ff @(posedge pclk) begin
    if (dm_we) dmem[dm_wa] <= dm_wd;
    if (ctx_we) begin
      ctx_src[s.ch]  <= s.src;
      ctx_dst[s.ch]  <= s.dst;
      ctx_left[s.ch] <= s.wr_left;
      ctx_dsc[s.ch]  <= ctx_dw;
    end
  end

  // outputs straight from flops
  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign cpu_ack   = s.cpu_ack;
  assign cpu_rdata = s.cpu_rdata;
  assign spoke_o   = s.sp;
  assign done_irq0 = s.irq0;
  assign done_irq1 = s.irq1;

endmodule : peripheral_hub_dma_controller
`default_nettype wire

// [test/hub_dma_props.sv]
// port assertions for the hub dma controller
`timescale 1ns/1ps
`default_nettype none
`include "hub_dma_regs.svh"
module hub_dma_props
  import hub_dma_pkg::*;
(
  // clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // register bus
  input wire logic [11:0]                 paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // processor and spokes
  input wire logic                        cpu_req,
  input wire logic                        cpu_ack,
  input wire spoke_out_s [`NUM_SPOKE-1:0] spoke_o,
  input wire logic [`NUM_SPOKE-1:0]       spoke_ack,
  // completion pulses
  input wire logic [`NUM_CH-1:0]          done_irq0
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // register bus, processor port, completion pulses, spokes
  // ****************************************
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup cycle");
  AST_READY_ACCESS: assert property (
    pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside an access cycle");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED_ERR: assert property (
    psel && penable && pready && paddr > `OFF_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  AST_UNMAPPED_ZERO: assert property (
    pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returns data");
  AST_CPU_ACK_PULSE: assert property (cpu_ack |=> !cpu_ack)
    else $error("processor ack longer than one cycle");
  AST_CPU_ACK_CAUSE: assert property (
    cpu_ack |-> $past(cpu_req) && $past(cpu_req, 2) && $past(|spoke_ack))
    else $error("processor ack without spoke ack");
  AST_IRQ_PULSE: assert property ((|done_irq0) |=> !(|done_irq0))
    else $error("completion pulse too long");
  for (genvar k = 0; k < `NUM_SPOKE; k++) begin : g_spoke
    AST_SPOKE_HOLD: assert property (
      spoke_o[k].req && !spoke_ack[k] |=> spoke_o[k].req
      && $stable(spoke_o[k].addr) && $stable(spoke_o[k].wdata))
      else $error("spoke request changed before ack");
    AST_SPOKE_DECODE: assert property (
      spoke_o[k].req |-> spoke_o[k].addr[`SPOKE_MSB:`SPOKE_LSB] == 3'(k))
      else $error("request on wrong spoke");
  end
  AST_POOL_HIDDEN: assert property (
    spoke_o[2].req |-> spoke_o[2].addr[`LOC_MSB:`LOC_LSB] != 5'h0)
    else $error("descriptor pool access left the hub");
endmodule : hub_dma_props
bind peripheral_hub_dma_controller hub_dma_props u_props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
  .spoke_o(spoke_o), .spoke_ack(spoke_ack), .done_irq0(done_irq0)
);
`default_nettype wire

// [test/hub_spoke_model.sv]
// peripherals answering on the eight spokes
`timescale 1ns/1ps
`default_nettype none
`include "hub_dma_regs.svh"
module hub_spoke_model
  import hub_dma_pkg::*;
#(
  parameter logic [31:0] RD_MASK = 32'h0004_a5a0
)
(
  // clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // wait cycles before each ack
  input wire logic [3:0]                  lat,
  // spoke bus
  input wire spoke_out_s [`NUM_SPOKE-1:0] spoke_o,
  output logic [`NUM_SPOKE-1:0]           spoke_ack,
  output logic [`NUM_SPOKE-1:0][31:0]     spoke_rdata
);
  logic [`NUM_SPOKE-1:0][3:0] wait_cnt;
  // ack after lat cycles; idle data toggles so it is never stale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spoke_ack   <= '0;
      wait_cnt    <= '0;
      spoke_rdata <= '0;
    end else begin
      for (int k = 0; k < `NUM_SPOKE; k++) begin
        spoke_ack[k]   <= 1'b0;
        spoke_rdata[k] <= ~spoke_rdata[k];
        if (spoke_o[k].req && !spoke_ack[k]) begin
          if (wait_cnt[k] >= lat) begin
            spoke_ack[k]   <= 1'b1;
            wait_cnt[k]    <= 4'h0;
            spoke_rdata[k] <= spoke_o[k].addr ^ RD_MASK;
          end else begin
            wait_cnt[k] <= wait_cnt[k] + 4'h1;
          end
        end
      end
    end
  end
endmodule : hub_spoke_model
`default_nettype wire

// [test/test_peripheral_hub_dma_controller.sv]
// self-checking bench for the hub dma controller
`timescale 1ns/1ps
`default_nettype none
`include "hub_dma_regs.svh"
module test_peripheral_hub_dma_controller
  import hub_dma_pkg::*;
;
  localparam logic [31:0] MASK = 32'h0004_a5a0;
  logic                        pclk, presetn, psel, penable, pwrite;
  logic                        pready, pslverr, cpu_req, cpu_we, cpu_ack;
  logic [11:0]                 paddr;
  logic [1:0]                  cpu_size;
  logic [31:0]                 pwdata, prdata, cpu_addr, cpu_wdata, cpu_rdata;
  spoke_out_s [`NUM_SPOKE-1:0] spoke_o;
  logic [`NUM_SPOKE-1:0]       spoke_ack;
  logic [`NUM_SPOKE-1:0][31:0] spoke_rdata;
  logic [`NUM_CH-1:0]          trig_in, done_irq0, done_irq1;
  logic [`NUM_CH-1:0]          irq_seen = '0;
  logic [3:0]                  lat;
  logic [31:0]                 wr_addr[8], wr_data[8], rd_addr[8];
  logic [1:0]                  wr_size[8];
  int                          wr_n[8] = '{default: 0};
  int                          err_total, n_compared;
  // ****************************************
  // design, peripherals, monitor
  // ****************************************
  peripheral_hub_dma_controller DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_size(cpu_size), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
    .spoke_o(spoke_o), .spoke_ack(spoke_ack), .spoke_rdata(spoke_rdata),
    .trig_in(trig_in), .done_irq0(done_irq0), .done_irq1(done_irq1));
  hub_spoke_model #(.RD_MASK(MASK)) u_spokes (
    .pclk(pclk), .presetn(presetn), .lat(lat), .spoke_o(spoke_o),
    .spoke_ack(spoke_ack), .spoke_rdata(spoke_rdata));
  // record finished spoke beats and completion pulses
  always @(posedge pclk) begin
    irq_seen <= irq_seen | done_irq0;
    for (int k = 0; k < 8; k++) begin
      if (spoke_o[k].req && spoke_ack[k] && spoke_o[k].we) begin
        wr_addr[k] <= spoke_o[k].addr;
        wr_data[k] <= spoke_o[k].wdata;
        wr_size[k] <= spoke_o[k].size;
        wr_n[k]    <= wr_n[k] + 1;
      end else if (spoke_o[k].req && spoke_ack[k]) begin
        rd_addr[k] <= spoke_o[k].addr;
      end
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) err_total++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0, q, e);
    check(q, exp);
  endtask : rdc
  task automatic set_desc(input int d, input logic [31:0] s, t, c, l);
    wr(12'(16 * d), s);
    wr(12'(16 * d + 4), t);
    wr(12'(16 * d + 8), c);
    wr(12'(16 * d + 12), l);
  endtask : set_desc
  task automatic chan(input int ch, input logic [31:0] cfg);
    wr(12'(`OFF_CHCFG + 4 * ch), cfg);
  endtask : chan
  task automatic wait_irq(input int ch);
    int n;
    n = 0;
    while (done_irq0[ch] !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) err_total++;
  endtask : wait_irq
  task automatic cpu_chk(input logic [31:0] a);
    int n;
    n = 0;
    cpu_req  <= 1'b1;
    cpu_addr <= a;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 200);
    check(cpu_rdata, a ^ MASK);
    cpu_req <= 1'b0;
    @(posedge pclk);
  endtask : cpu_chk
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // ****************************************
  // clock, watchdog, test sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    complete_run();
  end
  initial begin
    logic [31:0] q, src, lane;
    logic        e;
    int          n0;
    {presetn, psel, penable, pwrite, cpu_req, cpu_we} = '0;
    {paddr, pwdata, cpu_addr, cpu_wdata, trig_in} = '0;
    cpu_size = 2'h3;
    lat = 4'h2;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // control, cancel and refused accesses
    rdc(`OFF_CTRL, 32'h0);
    wr(`OFF_CTRL, 32'h1);
    rdc(`OFF_CTRL, 32'h1);
    wr(`OFF_CTRL, 32'h0);
    rdc(`OFF_CANCEL, 32'h0);
    apb(12'hc20, 1'b0, 32'h0, q, e);
    check(e, 1'b1);
    wr(12'h03c, 32'h0000_0285);
    rdc(12'h03c, 32'h0000_0285);
    // one beat of each width from spoke 1 to spoke 3
    for (int s = 0; s < 4; s++) begin
      src = 32'h0001_0000 + 32'h100 * s;
      set_desc(s, src, src + 32'h2_0000, 32'h0c00_0000 | (s << 24) | (s + 1),
               32'h0380);
      chan(0, 32'h3 | (s << 10));
      wr(`OFF_SWTRIG, 32'h1);
      wait_irq(0);
      check(done_irq1[0], 1'b1);
      lane = (s == 3) ? '1 : (32'h1 << (8 * (s + 1))) - 1;
      check(wr_addr[3], src + 32'h2_0000);
      check(wr_data[3] & lane, (src ^ MASK) & lane);
      check(wr_size[3], s);
      check(rd_addr[1], src);
    end
    // fetched address patches the source of the next descriptor
    set_desc(4, 32'h0001_0100, 32'h0002_0050, 32'h0300_0004, 32'h0405);
    set_desc(5, 32'h0001_0200, 32'h0004_0000, 32'h0300_0004, 32'h0180);
    chan(1, 32'h2 | (4 << 10));
    wr(`OFF_SWTRIG, 32'h2);
    wait_irq(1);
    check(rd_addr[5], 32'h0001_0100 ^ MASK);
    check(wr_data[4], 32'h0001_0100);
    wr(12'h040, 32'h0001_0300);
    wr(`OFF_SWTRIG, 32'h2);
    wait_irq(1);
    check(rd_addr[5], 32'h0001_0300 ^ MASK);
    // pin trigger, then completion of one channel starts another
    set_desc(8, 32'h0006_0000, 32'h0007_0000, 32'h0300_0004, 32'h0180);
    set_desc(9, 32'h0006_0010, 32'h0000_0040, 32'h0300_0004, 32'h0180);
    chan(4, 32'h4 | (8 << 10));
    chan(5, 32'h14 | (4 << 5) | (9 << 10));
    trig_in[4] <= 1'b1;
    @(posedge pclk);
    trig_in[4] <= 1'b0;
    wait_irq(5);
    check(wr_addr[0], 32'h0000_0040);
    // priority order while the processor reads on spoke 6 and on the channels' source spoke 1
    lat <= 4'h0;
    set_desc(10, 32'h0001_0400, 32'h0003_0400, 32'h0300_0004, 32'h0180);
    set_desc(11, 32'h0001_0500, 32'h0003_0500, 32'h0300_0004, 32'h0180);
    chan(6, 32'h6 | (10 << 10));
    chan(7, 32'h1 | (11 << 10));
    wr(`OFF_SWTRIG, 32'h0c0);
    fork
      begin
        wait_irq(7);
        check(irq_seen[6], 1'b0);
      end
      begin
        cpu_chk(32'h0006_0080);
        cpu_chk(32'h0001_0080);
      end
    join
    wait_irq(6);
    // stalled channel makes no beats, cancel ends an endless run
    set_desc(12, 32'h0001_0600, 32'h0003_0600, 32'h0301_0000, 32'h0180);
    chan(8, 32'h4 | (12 << 10));
    wr(`OFF_STALL, 32'h100);
    wr(`OFF_SWTRIG, 32'h100);
    n0 = wr_n[3];
    repeat (40) @(posedge pclk);
    check(wr_n[3], n0);
    wr(`OFF_STALL, 32'h0);
    repeat (40) @(posedge pclk);
    check(wr_n[3] > n0, 1'b1);
    wr(`OFF_CANCEL, 32'h100);
    repeat (20) @(posedge pclk);
    rdc(`OFF_SWTRIG, 32'h0);
    apb(`OFF_STATUS, 1'b0, 32'h0, q, e);
    check(q[5], 1'b0);
    check(irq_seen[8], 1'b0);
    complete_run();
  end
endmodule : test_peripheral_hub_dma_controller
`default_nettype wire
